// ---- include/asrr_pkg.sv ----
package asrr_pkg;

    // ****************************************
    // Widths and depths
    // ****************************************
    localparam int RESULT_W    = 14;
    localparam int FIFO_DEPTH  = 8;
    localparam int EDGE_W      = 5;
    localparam int FRAME_CNT_W = 16;

    // ****************************************
    // Frame timing
    // ****************************************
    // Rising link clock edge after which the output floats again.
    localparam logic [EDGE_W-1:0] LAST_EDGE   = 5'h11;
    // Number of result bits, as an edge count.
    localparam logic [EDGE_W-1:0] RESULT_EDGE = 5'h0e;
    localparam logic [EDGE_W-1:0] EDGE_ONE    = 5'h01;
    localparam logic [EDGE_W-1:0] MSB_INDEX   = 5'h0d;

    // ****************************************
    // Reset value and frame count step
    // ****************************************
    localparam logic [RESULT_W-1:0]    RESULT_RST = 14'h0000;
    localparam logic [FRAME_CNT_W-1:0] FRAME_ONE  = 16'h0001;

endpackage

// ---- include/asrr_stream_if.sv ----
`timescale 1ns/10ps
interface asrr_stream_if #(
    parameter int WIDTH = 14
);
    logic             valid;
    logic             ready;
    logic [WIDTH-1:0] data;

    modport src (
        output valid,
        output data,
        input  ready
    );
    modport snk (
        input  valid,
        input  data,
        output ready
    );
endinterface

// ---- hdl/asrr_fifo.sv ----
`timescale 1ns/10ps
module asrr_fifo #(
    parameter int WIDTH = 14,
    parameter int DEPTH = 8
) (
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             rst_n,
    // Filling side
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    // Draining side
    asrr_stream_if.src            out
);

    localparam int PTR_W = $clog2(DEPTH);
    localparam int CNT_W = $clog2(DEPTH + 1);
    localparam logic [CNT_W-1:0] FULL_CNT = CNT_W'(DEPTH);
    localparam logic [PTR_W-1:0] LAST_PTR = PTR_W'(DEPTH - 1);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [PTR_W-1:0]            wr_ptr;
        logic [PTR_W-1:0]            rd_ptr;
        logic [CNT_W-1:0]            count;
    } asrr_fifo_st_t;

    asrr_fifo_st_t st;
    asrr_fifo_st_t next_st;
    logic          push;
    logic          pop;

    assign in_ready  = (st.count != FULL_CNT);
    assign out.valid = (st.count != '0);
    assign out.data  = st.mem[st.rd_ptr];
    assign push      = in_valid && in_ready;
    assign pop       = out.valid && out.ready;

    always_comb begin
        next_st = st;
        if (push) begin
            next_st.mem[st.wr_ptr] = in_data;
            next_st.wr_ptr = (st.wr_ptr == LAST_PTR) ? '0 : st.wr_ptr + 1'b1;
        end
        if (pop) begin
            next_st.rd_ptr = (st.rd_ptr == LAST_PTR) ? '0 : st.rd_ptr + 1'b1;
        end
        if (push && !pop) begin
            next_st.count = st.count + 1'b1;
        end else if (pop && !push) begin
            next_st.count = st.count - 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

endmodule

// ---- hdl/asrr_readout.sv ----
`timescale 1ns/10ps
module asrr_readout (
    // System clock and reset
    input  wire logic                               clk,
    input  wire logic                               rst_n,
    // Conversion results from the converter core
    input  wire logic [asrr_pkg::RESULT_W-1:0]      result_data,
    input  wire logic                               result_valid,
    output logic                                    result_ready,
    // Serial link pins
    input  wire logic                               sclk,
    input  wire logic                               frame_sync_n,
    output logic                                    serial_result_out,
    output logic                                    serial_result_oe,
    // Status
    output logic                                    frame_active,
    output logic                                    stale_frame,
    output logic [asrr_pkg::FRAME_CNT_W-1:0]        frame_count
);

    // ****************************************
    // Result buffer
    // ****************************************
    asrr_stream_if #(.WIDTH(asrr_pkg::RESULT_W)) fifo_out ();

    asrr_fifo #(
        .WIDTH (asrr_pkg::RESULT_W),
        .DEPTH (asrr_pkg::FIFO_DEPTH)
    ) u_fifo (
        .clk      (clk),
        .rst_n    (rst_n),
        .in_valid (result_valid),
        .in_ready (result_ready),
        .in_data  (result_data),
        .out      (fifo_out)
    );

    // ****************************************
    // System clock side
    // ****************************************
    typedef struct packed {
        logic                             fs_meta;
        logic                             fs_sync;
        logic                             fs_prev;
        logic [asrr_pkg::RESULT_W-1:0]    shadow;
        logic                             fresh;
        logic                             stale;
        logic [asrr_pkg::FRAME_CNT_W-1:0] frames;
    } asrr_sys_st_t;

    asrr_sys_st_t sys;
    asrr_sys_st_t next_sys;
    logic         idle_stable;

    // The shadow word is only rewritten while two successive synchronised samples of frame sync
    // are idle, so it can still change on the first two clk edges after frame_sync_n falls.
    assign idle_stable    = sys.fs_sync && sys.fs_prev;
    assign fifo_out.ready = idle_stable && !sys.fresh;

    always_comb begin
        next_sys         = sys;
        next_sys.fs_meta = frame_sync_n;
        next_sys.fs_sync = sys.fs_meta;
        next_sys.fs_prev = sys.fs_sync;
        next_sys.stale   = 1'b0;
        if (fifo_out.valid && fifo_out.ready) begin
            next_sys.shadow = fifo_out.data;
            next_sys.fresh  = 1'b1;
        end
        // A frame start consumes the shadow word; a repeat read is flagged.
        if (sys.fs_prev && !sys.fs_sync) begin
            next_sys.fresh  = 1'b0;
            next_sys.stale  = !sys.fresh;
            next_sys.frames = sys.frames + asrr_pkg::FRAME_ONE;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            sys        <= '0;
            sys.fs_meta <= 1'b1;
            sys.fs_sync <= 1'b1;
            sys.fs_prev <= 1'b1;
        end else begin
            sys <= next_sys;
        end
    end

    assign frame_active = !sys.fs_sync;
    assign stale_frame  = sys.stale;
    assign frame_count  = sys.frames;

    // ****************************************
    // Link clock side
    // ****************************************
    typedef struct packed {
        logic [asrr_pkg::EDGE_W-1:0] edges;
    } asrr_link_st_t;

    asrr_link_st_t                link;
    asrr_link_st_t                next_link;
    logic [asrr_pkg::EDGE_W-1:0]  bit_index;
    logic                         in_data_bits;

    always_comb begin
        next_link = link;
        if (link.edges != asrr_pkg::LAST_EDGE) begin
            next_link.edges = link.edges + asrr_pkg::EDGE_ONE;
        end
    end

    // The link clock stops between frames, so frame sync itself is the reset.
    // clear on frame end
    always_ff @(posedge sclk or posedge frame_sync_n) begin
        if (frame_sync_n) begin
            link <= '0;
        end else begin
            link <= next_link;
        end
    end

    assign bit_index    = asrr_pkg::MSB_INDEX - link.edges;
    assign in_data_bits = (link.edges < asrr_pkg::RESULT_EDGE);

    assign serial_result_out = in_data_bits ? sys.shadow[bit_index[3:0]] : 1'b0;

    assign serial_result_oe = !frame_sync_n && (link.edges != asrr_pkg::LAST_EDGE);

endmodule

// ---- bench/asrr_readout_sva.sv ----
`timescale 1ns/10ps
module asrr_readout_sva (
    // Clocks and reset
    input wire logic clk,
    input wire logic rst_n,
    input wire logic sclk,
    // Link and status
    input wire logic frame_sync_n,
    input wire logic serial_result_out,
    input wire logic serial_result_oe,
    input wire logic frame_active,
    input wire logic stale_frame
);
    logic [4:0] cnt;
    // Cleared by frame sync, because the link side has no reset of its own.
    always_ff @(posedge sclk or posedge frame_sync_n) begin
        if (frame_sync_n) begin
            cnt <= 5'h00;
        end else if (cnt != 5'h1f) begin
            cnt <= cnt + 5'h01;
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    AST_FLOAT: assert property (frame_sync_n |-> !serial_result_oe)
        else $error("driven while idle");
    AST_START: assert property ($fell(frame_sync_n) |-> serial_result_oe)
        else $error("no drive at start");
    AST_SYNC: assert property ($fell(frame_sync_n) |-> ##[1:3] frame_active)
        else $error("frame not seen");
    AST_DATA: assert property (!frame_sync_n && cnt < 5'h0e |-> serial_result_oe)
        else $error("dropped early");
    AST_STEADY: assert property (serial_result_oe && !$past(frame_sync_n, 4)
        && $stable(cnt) |-> $stable(serial_result_out)) else $error("bit moved");
    AST_PAD: assert property (cnt inside {[5'h0e:5'h10]} |-> serial_result_oe)
        else $error("dropped before last edge");
    AST_LAST: assert property (cnt > 5'h10 |-> !serial_result_oe)
        else $error("driven after last edge");
    AST_CLOSE: assert property ($rose(frame_sync_n) |-> !serial_result_oe[*2])
        else $error("driven after close");
    cover property (cnt == 5'h11);
    cover property (stale_frame);
    cover property ($fell(frame_sync_n));
endmodule
bind asrr_readout asrr_readout_sva chk_u (.clk(clk), .rst_n(rst_n), .sclk(sclk),
    .frame_sync_n(frame_sync_n), .serial_result_out(serial_result_out),
    .serial_result_oe(serial_result_oe), .frame_active(frame_active),
    .stale_frame(stale_frame));

// ---- bench/asrr_host.sv ----
`timescale 1ns/10ps
module asrr_host (
    // Link pins
    output logic      sclk,
    output logic      frame_sync_n,
    input  wire logic result_pin
);
    initial begin
        sclk = 1'b1;
        frame_sync_n = 1'b1;
    end
    // The clock rests high, so the first edge of a frame is falling and reads the top bit.
    task automatic read_frame(input int edges, output logic [13:0] word);
        word = 14'h0000;
        frame_sync_n = 1'b0;
        #150;
        for (int i = 0; i < edges; i++) begin
            sclk = 1'b0;
            if (i < 14) word = {word[12:0], result_pin};
            #32 sclk = 1'b1;
            #32;
        end
    endtask
    task automatic end_frame();
        frame_sync_n = 1'b1;
        #200;
    endtask
endmodule

// ---- bench/asrr_readout_bench.sv ----
`timescale 1ns/10ps
module asrr_readout_bench;
    logic        clk, rst_n, result_valid, result_ready, sclk, frame_sync_n;
    logic        serial_result_out, serial_result_oe, frame_active, stale_frame;
    logic [13:0] result_data, word;
    logic [15:0] frame_count;
    wire         result_pin;
    int          n_errors = 0, n_compared = 0, n_stale = 0, cycles = 0;
    assign result_pin = serial_result_oe ? serial_result_out : 1'bz;
    asrr_readout dut_u (.*);
    asrr_host host_u (.sclk(sclk), .frame_sync_n(frame_sync_n), .result_pin(result_pin));
    always #20 clk = ~clk;
    always @(negedge clk) if (stale_frame === 1'b1) n_stale++;
    always @(posedge clk) begin
        cycles++;
        if (cycles == 2000) begin
            n_errors++;
            stop_test();
        end
    end
    task automatic check(input string what, input logic [15:0] seen, exp);
        n_compared++;
        if (seen !== exp) begin
            n_errors++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic stop_test();
        $display("compared %0d errors %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic push(input logic [13:0] w);
        @(negedge clk);
        while (result_ready !== 1'b1) @(negedge clk);
        result_valid = 1'b1;
        result_data = w;
        @(negedge clk);
        result_valid = 1'b0;
    endtask
    // Six idle cycles give the shadow word time to reload before the frame.
    task automatic frame(input int edges, input logic [13:0] exp);
        repeat (6) @(negedge clk);
        host_u.read_frame(edges, word);
        check("word", word, exp);
        check("oe at end", serial_result_oe, edges < 17);
        check("active", frame_active, 1'b1);
        host_u.end_frame();
        check("oe idle", serial_result_oe, 1'b0);
        check("inactive", frame_active, 1'b0);
    endtask
    task automatic sc_single(input int edges, input logic [13:0] w);
        push(w);
        frame(edges, w);
    endtask
    task automatic sc_stale();
        frame(16, 14'h1396);
        check("stale", n_stale[15:0], 16'h0001);
    endtask
    task automatic sc_fifo();
        for (int i = 0; i < 9; i++) push(14'h0123 * i[13:0]);
        check("ready full", result_ready, 1'b0);
        for (int i = 0; i < 9; i++) frame(16 + i % 2, 14'h0123 * i[13:0]);
        check("ready empty", result_ready, 1'b1);
        check("frames", frame_count, 16'h000c);
        check("no new stale", n_stale[15:0], 16'h0001);
    endtask
    initial begin
        clk = 1'b0;
        rst_n = 1'b0;
        result_valid = 1'b0;
        result_data = 14'h0000;
        repeat (4) @(negedge clk);
        rst_n = 1'b1;
        sc_single(17, 14'h2d69);
        sc_single(16, 14'h1396);
        sc_stale();
        sc_fifo();
        stop_test();
    end
endmodule
